// ==== osd_pkg.sv ====
package osd_pkg;

    // register map and bus geometry
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          REG_W        = 16;
    localparam logic [7:0]  CSR_OFFSET   = 8'h00;

    // field positions inside the control/status register
    localparam int          NUM_REQ      = 4;
    localparam int          MODE_W       = 2;
    localparam int          MODE_LSB     = 0;
    localparam int          IE_BIT       = 8;
    localparam int          RSV_LSB      = 9;
    localparam int          RSV_MSB      = 11;
    localparam int          FLAG_LSB     = 12;
    localparam int          CTRL_W       = 9;

    // reset values
    localparam logic [15:0] CSR_RESET    = 16'h0000;
    localparam logic [8:0]  CTRL_RESET   = 9'h000;
    localparam logic [3:0]  FLAG_RESET   = 4'h0;

    // low-level sampling: divider ratios and number of low samples
    localparam int          DIV8         = 8;
    localparam int          DIV16        = 16;
    localparam int          DIV128       = 128;
    localparam int          PRESC_W      = 7;
    localparam int          SAMPLE_COUNT = 16;
    localparam int          CNT_W        = 5;

    // synchroniser depth on the request pins
    localparam int          SYNC_STAGES  = 3;

    typedef enum logic [1:0] {
        OSD_MODE_EDGE   = 2'b00,
        OSD_MODE_DIV8   = 2'b01,
        OSD_MODE_DIV16  = 2'b10,
        OSD_MODE_DIV128 = 2'b11
    } osd_mode_type;

endpackage

// ==== osd_sync.sv ====
module osd_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,      // peripheral clock
    input  wire logic             rst_n,    // synchronous reset, active low
    input  wire logic [WIDTH-1:0] async_n,  // raw request pins, active low
    output logic      [WIDTH-1:0] level_n   // filtered level, active low
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
    wire  [WIDTH-1:0] next_level = (stage2 & agree) | (level_n & ~agree);

    // three flops, change taken on agreement
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1  <= '1;
            stage2  <= '1;
            stage3  <= '1;
            level_n <= '1;
        end else begin
            stage1  <= async_n;
            stage2  <= stage1;
            stage3  <= stage2;
            level_n <= next_level;
        end
    end

    chk_sync_agree: assert property (
        @(posedge clk) disable iff (!rst_n)
        (level_n != $past(level_n)) |-> $past(stage2 == stage3))
        else $error("filtered level changed without stage agreement");

endmodule // osd_sync

// ==== osd_detect.sv ====
module osd_detect (
    input  wire logic       clk,     // peripheral clock
    input  wire logic       rst_n,   // synchronous reset, active low
    input  wire logic       level_n, // synchronised request level
    input  wire logic [1:0] mode,    // detection mode code
    input  wire logic       tick,    // sampling tick for the mode
    output logic            detect   // request accepted: one-cycle pulse in mode 00, level otherwise
);
    logic [osd_pkg::CNT_W-1:0] low_cnt;
    logic                      level_d;
    logic [1:0]                mode_d;

    localparam logic [osd_pkg::CNT_W-1:0] FULL =
        osd_pkg::CNT_W'(osd_pkg::SAMPLE_COUNT);

    wire edge_mode = (mode == osd_pkg::OSD_MODE_EDGE);
    wire fell      = level_d & ~level_n;
    wire restart   = (mode != mode_d) | edge_mode;
    wire [osd_pkg::CNT_W-1:0] next_cnt =
        restart              ? '0 :
        !tick                ? low_cnt :
        level_n              ? '0 :
        (low_cnt == FULL)    ? low_cnt :
                               low_cnt + osd_pkg::CNT_W'(1);
    // sixteen consecutive low samples otherwise
    // a saturated count must not keep the request up once the pin is high
    wire next_detect = edge_mode ? fell : ((next_cnt == FULL) & ~level_n);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_cnt <= '0;
            level_d <= 1'b1;
            mode_d  <= 2'b00;
            detect  <= 1'b0;
        end else begin
            low_cnt <= next_cnt;
            level_d <= level_n;
            mode_d  <= mode;
            detect  <= next_detect;
        end
    end

    chk_edge_accept: assert property (
        @(posedge clk) disable iff (!rst_n)
        (edge_mode && level_d && !level_n) |=> detect)
        else $error("falling edge not accepted in edge mode");

    chk_low_count: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!$past(edge_mode) && detect) |->
            (low_cnt == FULL) && !$past(level_n))
        else $error("level request accepted before sixteen low samples");

endmodule // osd_detect

// ==== osd_top.sv ====
// Functional notes
// - one 16-bit control/status register, all implemented bits reset to 0
// - bit 15 flags input 3 per mode in bits 7:6
// - bit 14 flags input 2 per mode in bits 5:4
// - bit 13 flags input 1 per mode in bits 3:2
// - bit 12 flags input 0 per mode in bits 1:0
// - a flag clears only by writing 0 after reading it as 1
// - reserved bits 11 to 9 read as 0
// - interrupt when any flag set and enable bit 8 is 1
// - mode 00 accepts a request on a falling input edge
// - nonzero modes need sixteen consecutive low samples
// - sampling rates are clock divided by 8, 16 and 128
// - any accepted request drives high-current pins to high impedance
// - writing 1 to a flag has no effect
module osd_top (
    input  wire logic                        clk,      // peripheral clock
    input  wire logic                        rst_n,    // sync reset, low
    input  wire logic                        psel,     // apb select
    input  wire logic                        penable,  // apb enable
    input  wire logic                        pwrite,   // apb direction
    input  wire logic [osd_pkg::ADDR_W-1:0]  paddr,    // apb byte address
    input  wire logic [osd_pkg::DATA_W-1:0]  pwdata,   // apb write data
    output logic      [osd_pkg::DATA_W-1:0]  prdata,   // apb read data
    output logic                             pready,   // apb ready
    output logic                             pslverr,  // apb error
    input  wire logic [osd_pkg::NUM_REQ-1:0] shutdown_request_inputs_n, // pins
    output logic                             irq,      // interrupt request
    output logic                             hiz_req   // pins to high-z
);
    localparam int N = osd_pkg::NUM_REQ;

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [osd_pkg::CTRL_W-1:0]  ctrl;
    logic [N-1:0]                flag;
    logic [N-1:0]                armed;
    logic [osd_pkg::PRESC_W-1:0] presc;

    wire [N-1:0] level_n;
    wire [N-1:0] detect;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    function automatic logic [1:0] mode_of(
        input logic [osd_pkg::CTRL_W-1:0] c,
        input int                         idx
    );
        mode_of = c[osd_pkg::MODE_LSB + osd_pkg::MODE_W*idx +: 2];
    endfunction

    // true on the last count of a divider period
    function automatic logic period_end(
        input logic [osd_pkg::PRESC_W-1:0] cnt,
        input int                          div
    );
        logic [osd_pkg::PRESC_W-1:0] mask;
        mask = osd_pkg::PRESC_W'(div - 1);
        period_end = ((cnt & mask) == mask);
    endfunction

    // mode code chooses the sampling rate
    function automatic logic tick_for(
        input logic [1:0]                  mode,
        input logic [osd_pkg::PRESC_W-1:0] cnt
    );
        unique case (osd_pkg::osd_mode_type'(mode))
            osd_pkg::OSD_MODE_EDGE:   tick_for = 1'b0;
            osd_pkg::OSD_MODE_DIV8:   tick_for = period_end(cnt, osd_pkg::DIV8);
            osd_pkg::OSD_MODE_DIV16:  tick_for = period_end(cnt,
                                                            osd_pkg::DIV16);
            osd_pkg::OSD_MODE_DIV128: tick_for = period_end(cnt,
                                                            osd_pkg::DIV128);
        endcase
    endfunction

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire addr_hit  = (paddr == osd_pkg::CSR_OFFSET);
    wire setup     = psel & ~penable;
    wire access_ok = psel & penable & pready;
    wire wr_done   = access_ok & pwrite & addr_hit;
    wire rd_done   = access_ok & ~pwrite & addr_hit;

    wire [osd_pkg::REG_W-1:0] csr_view = {
        flag,
        3'b000,
        ctrl
    };

    wire [osd_pkg::DATA_W-1:0] next_prdata =
        (setup & ~pwrite & addr_hit) ? {16'h0000, csr_view} : '0;

    // flags seen as 1 by the read just completed
    wire [N-1:0] read_ones =
        prdata[osd_pkg::FLAG_LSB +: N] & {N{rd_done}};

    wire [N-1:0] wr_flag_bits = pwdata[osd_pkg::FLAG_LSB +: N];

    // a zero clears only an armed flag
    // a one written to a flag is ignored
    wire [N-1:0] clr = {N{wr_done}} & armed & ~wr_flag_bits;

    // reserved bits are masked off, never stored
    wire [osd_pkg::CTRL_W-1:0] next_ctrl =
        wr_done ? pwdata[osd_pkg::CTRL_W-1:0] : ctrl;

    // set wins over a clear in the same cycle
    wire [N-1:0] next_flag = detect | (flag & ~clr);

    wire [N-1:0] next_armed = wr_done ? '0 : (armed | read_ones);

    wire next_ie = next_ctrl[osd_pkg::IE_BIT];

    wire next_irq = next_ie & (|next_flag);

    // any accepted request forces high impedance
    wire next_hiz = |next_flag;

    // one free-running prescaler serves all three rates
    wire [osd_pkg::PRESC_W-1:0] next_presc = presc + osd_pkg::PRESC_W'(1);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // everything implemented resets to zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl    <= osd_pkg::CTRL_RESET;
            flag    <= osd_pkg::FLAG_RESET;
            armed   <= '0;
            presc   <= '0;
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
            hiz_req <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            flag    <= next_flag;
            armed   <= next_armed;
            presc   <= next_presc;
            prdata  <= next_prdata;
            pready  <= setup;
            pslverr <= setup & ~addr_hit;
            irq     <= next_irq;
            hiz_req <= next_hiz;
        end
    end

    // ------------------------------------------------------------------
    // input path: synchronise, then detect per input
    // ------------------------------------------------------------------
    // pins pass the synchroniser first
    osd_sync #(
        .WIDTH   (N)
    ) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .async_n (shutdown_request_inputs_n),
        .level_n (level_n)
    );

    for (genvar i = 0; i < N; i++) begin : g_det
        wire [1:0] mode_i = mode_of(ctrl, i);
        wire       tick_i = tick_for(mode_i, presc);

        osd_detect u_det (
            .clk     (clk),
            .rst_n   (rst_n),
            .level_n (level_n[i]),
            .mode    (mode_i),
            .tick    (tick_i),
            .detect  (detect[i])
        );

        // a detection sets the matching flag
        chk_flag_set: assert property (
            @(posedge clk) disable iff (!rst_n)
            detect[i] |=> flag[i])
            else $error("detection did not set its flag");

        // a fall needs an armed zero write
        chk_clear_armed: assert property (
            @(posedge clk) disable iff (!rst_n)
            (!flag[i] && $past(flag[i])) |->
                $past(wr_done && armed[i] &&
                      !pwdata[osd_pkg::FLAG_LSB + i]))
            else $error("flag cleared without read-then-write-zero");

        // a write alone never sets a flag
        chk_one_ignored: assert property (
            @(posedge clk) disable iff (!rst_n)
            (wr_done && !flag[i] && !detect[i]) |=> !flag[i])
            else $error("write of one set a request flag");

        chk_arm_read: assert property (
            @(posedge clk) disable iff (!rst_n)
            (rd_done && prdata[osd_pkg::FLAG_LSB + i]) |=> armed[i])
            else $error("read of a set flag did not arm it");

        chk_disarm_write: assert property (
            @(posedge clk) disable iff (!rst_n)
            wr_done |=> !armed[i])
            else $error("write left a flag armed");

        chk_flag_sticky: assert property (
            @(posedge clk) disable iff (!rst_n)
            (flag[i] && !wr_done) |=> flag[i])
            else $error("flag dropped without a write");
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // zero after reset
    chk_reset_zero: assert property (
        @(posedge clk)
        (!$past(rst_n) && rst_n) |->
            (csr_view == osd_pkg::CSR_RESET) && !irq && !hiz_req)
        else $error("register not zero after reset");

    chk_reserved_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (pready && !pwrite) |->
            (prdata[osd_pkg::RSV_MSB:osd_pkg::RSV_LSB] == 3'b000) &&
            (prdata[osd_pkg::DATA_W-1:osd_pkg::REG_W] == 16'h0000))
        else $error("reserved bits read nonzero");

    chk_irq_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        ##1 (irq == ((|flag) && ctrl[osd_pkg::IE_BIT])))
        else $error("interrupt does not follow flags and enable");

    chk_hiz_follow: assert property (
        @(posedge clk) disable iff (!rst_n)
        (|detect) |=> hiz_req && (|flag))
        else $error("high impedance request missing with flag set");

    chk_tick8_period: assert property (
        @(posedge clk) disable iff (!rst_n)
        period_end(presc, osd_pkg::DIV8) |=>
            !period_end(presc, osd_pkg::DIV8) [*7] ##1
            period_end(presc, osd_pkg::DIV8))
        else $error("divide-by-8 tick period wrong");

    chk_tick128_rate: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mode_of(ctrl, 3) == osd_pkg::OSD_MODE_DIV128 &&
         g_det[3].tick_i) |-> (presc == 7'h7F))
        else $error("code 11 does not select divide by 128");

    chk_pready_once: assert property (
        @(posedge clk) disable iff (!rst_n)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb ready not a single access cycle");

    chk_irq_masked: assert property (
        @(posedge clk) disable iff (!rst_n)
        !ctrl[osd_pkg::IE_BIT] |-> !irq)
        else $error("interrupt raised while disabled");

    chk_hiz_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        hiz_req == (|flag))
        else $error("high impedance request differs from flags");

    chk_tick16_period: assert property (
        @(posedge clk) disable iff (!rst_n)
        period_end(presc, osd_pkg::DIV16) |=>
            !period_end(presc, osd_pkg::DIV16) [*8] ##1
            !period_end(presc, osd_pkg::DIV16) [*7] ##1
            period_end(presc, osd_pkg::DIV16))
        else $error("divide-by-16 tick period wrong");

    chk_edge_no_tick: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mode_of(ctrl, 0) == osd_pkg::OSD_MODE_EDGE) |-> !g_det[0].tick_i)
        else $error("edge mode produced a sampling tick");

    chk_tick8_rate: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mode_of(ctrl, 1) == osd_pkg::OSD_MODE_DIV8 &&
         g_det[1].tick_i) |-> (presc[2:0] == 3'h7))
        else $error("code 01 does not select divide by 8");

    chk_tick16_rate: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mode_of(ctrl, 2) == osd_pkg::OSD_MODE_DIV16 &&
         g_det[2].tick_i) |-> (presc[3:0] == 4'hF))
        else $error("code 10 does not select divide by 16");

    chk_err_unmapped: assert property (
        @(posedge clk) disable iff (!rst_n)
        (setup && !addr_hit) |=> pready && pslverr && (prdata == '0))
        else $error("unmapped access not answered with an error");

    chk_err_no_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (access_ok && !addr_hit) |=> $stable(ctrl))
        else $error("unmapped write changed the register");

    chk_read_value: assert property (
        @(posedge clk) disable iff (!rst_n)
        (setup && !pwrite && addr_hit) |=>
            (prdata == {16'h0000, $past(csr_view)}))
        else $error("read data differs from the register");

    chk_write_ctrl: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_done |=> (ctrl == $past(pwdata[osd_pkg::CTRL_W-1:0])))
        else $error("write did not store the control bits");

endmodule // osd_top

// ==== osd_fault_src.sv ====
module osd_fault_src (
    input  wire logic       clk,       // peripheral clock
    input  wire logic       rst_n,     // synchronous reset, active low
    input  wire logic [3:0] hold_low,  // keep a request pin low
    input  wire logic [3:0] pulse_go,  // start a short low pulse
    output logic      [3:0] pins_n     // request pins, active low
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] pulse_cnt;
    logic [3:0] pulse_mask;
    logic [3:0] pulse_low;

    // pins are pulled up, so a released request reads high
    assign pulse_low = (pulse_cnt != 3'h0) ? pulse_mask : 4'h0;
    assign pins_n    = ~(hold_low | pulse_low);

    // a pulse is four clocks long, enough to pass the pin filter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulse_cnt  <= 3'h0;
            pulse_mask <= 4'h0;
        end else if (pulse_go != 4'h0) begin
            pulse_cnt  <= 3'h4;
            pulse_mask <= pulse_go;
        end else if (pulse_cnt != 3'h0) begin
            pulse_cnt <= pulse_cnt - 3'h1;
        end
    end
endmodule // osd_fault_src

// ==== output_shutdown_input_detect_tb_top.sv ====
module output_shutdown_input_detect_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  pins_n;
    logic [3:0]  hold_low;
    logic [3:0]  pulse_go;
    logic        irq;
    logic        hiz_req;
    int          errors;
    int          n_tests;
    int          cyc;
    int          div;
    logic [15:0] fbit;
    localparam logic [15:0] CTRL = 16'h01E4;

    osd_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .shutdown_request_inputs_n(pins_n), .irq(irq), .hiz_req(hiz_req));

    osd_fault_src partner (.clk(clk), .rst_n(rst_n), .hold_low(hold_low),
        .pulse_go(pulse_go), .pins_n(pins_n));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic end_of_test;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 12000) begin
            errors++;
            $display("mismatch at %0t: run too long", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [15:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        forever begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        chk({31'h0, err}, 32'h0, "write error");
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e,
                          input logic ee);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 16'h0000, rd, err);
        chk(rd, {16'h0000, e}, "read data");
        chk({31'h0, err}, {31'h0, ee}, "slave error");
    endtask

    initial begin
        errors = 0;
        n_tests = 0;
        cyc = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hold_low = 4'h0;
        pulse_go = 4'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({30'h0, irq, hiz_req}, 32'h0, "idle outputs");
        rd_chk(8'h00, 16'h0000, 1'b0);
        wr(8'h00, CTRL);
        rd_chk(8'h00, CTRL, 1'b0);
        rd_chk(8'h04, 16'h0000, 1'b1);
        // falling edge on input 0 in mode 00
        @(posedge clk);
        pulse_go <= 4'h1;
        @(posedge clk);
        pulse_go <= 4'h0;
        repeat (14) @(posedge clk);
        chk({30'h0, irq, hiz_req}, 32'h3, "irq and hiz");
        wr(8'h00, CTRL);
        rd_chk(8'h00, 16'h11E4, 1'b0);
        wr(8'h00, 16'h10E4);
        @(posedge clk);
        chk({30'h0, irq, hiz_req}, 32'h1, "masked irq");
        rd_chk(8'h00, 16'h10E4, 1'b0);
        wr(8'h00, 16'h00E4);
        rd_chk(8'h00, 16'h00E4, 1'b0);
        chk({30'h0, irq, hiz_req}, 32'h0, "cleared");
        wr(8'h00, 16'hF1E4);
        rd_chk(8'h00, CTRL, 1'b0);
        // level modes: input 1 /8, input 2 /16, input 3 /128
        for (int i = 1; i < 4; i++) begin
            div = (i == 1) ? 8 : ((i == 2) ? 16 : 128);
            fbit = 16'h1000 << i;
            @(posedge clk);
            hold_low <= fbit[15:12];
            repeat (14 * div) @(posedge clk);
            rd_chk(8'h00, CTRL, 1'b0);
            repeat (3 * div + 10) @(posedge clk);
            rd_chk(8'h00, CTRL | fbit, 1'b0);
            chk({30'h0, irq, hiz_req}, 32'h3, "level irq");
            hold_low <= 4'h0;
            repeat (8) @(posedge clk);
            rd_chk(8'h00, CTRL | fbit, 1'b0);
            wr(8'h00, CTRL);
            rd_chk(8'h00, CTRL, 1'b0);
        end
        end_of_test();
    end
endmodule // output_shutdown_input_detect_tb_top
